// >>> inc/csgcr_pkg.sv
package csgcr_pkg;

	localparam int GATED_N   = 22;
	localparam int ADDR_W    = 16;
	localparam int BANK_W    = 3;
	localparam int CS_OUT_N  = 2;
	localparam int CS_IN_N   = 4;

	// cycles the error flag is held low, and flag blanking after reset release
	localparam logic [1:0] ERR_HOLD_CYCLES = 2'h2;
	localparam logic [1:0] BLANK_CYCLES    = 2'h3;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [BANK_W-1:0] bank;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
	} csgcr_cmd_t;

	typedef struct packed {
		logic [CS_OUT_N-1:0] cs_n;
		logic                cke;
		logic                odt;
	} csgcr_ctl_t;

	typedef struct packed {
		csgcr_ctl_t ctl;
		csgcr_cmd_t cmd;
	} csgcr_word_t;

	localparam csgcr_cmd_t  CMD_RST  = '0;
	localparam csgcr_word_t WORD_RST = '0;

	// even parity over the gated command bits
	function automatic logic csgcr_parity(input csgcr_cmd_t c);
		csgcr_parity = ^c;
	endfunction

	function automatic logic csgcr_any_cs(input logic [CS_IN_N-1:0] cs_n);
		csgcr_any_cs = ~&cs_n;
	endfunction

endpackage

// >>> logic/csgcr_buf.sv
`timescale 1ns/1ps
module csgcr_buf
	import csgcr_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// fill side
	input  wire logic        in_valid,
	output      logic        in_ready,
	input  wire csgcr_word_t in_word,
	// drain side
	output      logic        out_valid,
	input  wire logic        out_ready,
	output      csgcr_word_t out_word
);

	typedef struct packed {
		csgcr_word_t head;
		csgcr_word_t spare;
		logic        head_v;
		logic        spare_v;
	} csgcr_buf_st_t;

	csgcr_buf_st_t st_reg;
	csgcr_buf_st_t st_next;

	assign in_ready  = !st_reg.spare_v;
	assign out_valid = st_reg.head_v;
	assign out_word  = st_reg.head;

	always_comb begin
		st_next = st_reg;
		if (out_ready && st_reg.head_v) begin
			if (st_reg.spare_v) begin
				st_next.head    = st_reg.spare;
				st_next.spare_v = 1'b0;
			end else begin
				st_next.head_v = 1'b0;
			end
		end
		if (in_valid && in_ready) begin
			if (!st_next.head_v) begin
				st_next.head   = in_word;
				st_next.head_v = 1'b1;
			end else begin
				st_next.spare   = in_word;
				st_next.spare_v = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_buf_full;
		(clk_en && st_reg.head_v && !out_ready && in_valid && in_ready) |=> !in_ready;
	endproperty
	a_buf_full: assert property (p_buf_full) else $error("buffer not full after second word");

	c_buf_full: cover property (clk_en && !in_ready && !out_ready);

endmodule

// >>> logic/csgcr_perr.sv
`timescale 1ns/1ps
module csgcr_perr
	import csgcr_pkg::*;
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// mismatch seen on the parity sampling edge
	input  wire logic mismatch,
	// open-drain error pin
	output      logic flag_o,
	output      logic flag_oe
);

	typedef struct packed {
		logic       req;
		logic [1:0] hold;
		logic [1:0] blank;
	} csgcr_perr_st_t;

	csgcr_perr_st_t st_reg;
	csgcr_perr_st_t st_next;

	assign flag_o  = 1'b0;
	assign flag_oe = (st_reg.hold != 2'h0);

	always_comb begin
		st_next     = st_reg;
		st_next.req = mismatch;
		if (st_reg.blank != 2'h0) begin
			st_next.blank = st_reg.blank - 2'h1;
		end
		if (st_reg.hold != 2'h0) begin
			st_next.hold = st_reg.hold - 2'h1;
		end
		if (st_reg.req && st_reg.blank == 2'h0) begin
			st_next.hold = ERR_HOLD_CYCLES;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_reg       <= '0;
			st_reg.blank <= BLANK_CYCLES;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_err_delay;
		(clk_en && mismatch ##1 clk_en && st_reg.blank == 2'h0) |=> flag_oe;
	endproperty
	a_err_delay: assert property (p_err_delay) else $error("error not flagged");

	property p_err_two;
		(clk_en && $rose(flag_oe)) |-> flag_oe ##1 flag_oe;
	endproperty
	a_err_two: assert property (p_err_two) else $error("error pulse too short");

	property p_blank;
		($past(sys_rst) && !sys_rst) |-> !flag_oe [*3];
	endproperty
	a_blank: assert property (p_blank) else $error("flag driven during blanking");

	property p_od;
		flag_oe |-> !flag_o;
	endproperty
	a_od: assert property (p_od) else $error("open-drain pin driven high");

	c_err_pulse: cover property ($rose(flag_oe));

endmodule

// >>> logic/csgcr_top.sv
`timescale 1ns/1ps
module csgcr_top
	import csgcr_pkg::*;
(
	// clock, reset, enable
	input  wire logic                mclk,
	input  wire logic                sys_rst,
	input  wire logic                clk_en,
	// controller side
	input  wire logic                in_valid,
	output      logic                in_ready,
	input  wire csgcr_cmd_t          cmd_in,
	input  wire logic                chip_select_a,
	input  wire logic                chip_select_b,
	input  wire logic                chip_select_c,
	input  wire logic                chip_select_d,
	input  wire logic                cke_in,
	input  wire logic                odt_in,
	input  wire logic                parity_in,
	input  wire logic                gating_enable,
	// dram side
	output      logic                out_valid,
	input  wire logic                out_ready,
	output      csgcr_cmd_t          redriven_outputs,
	output      logic [CS_OUT_N-1:0] redriven_select_out,
	output      logic                redriven_cke,
	output      logic                redriven_odt,
	// shared open-drain error line
	input  wire logic                parity_error_flag_n_i,
	output      logic                parity_error_flag_n_o,
	output      logic                parity_error_flag_n_oe,
	output      logic                shared_error_seen
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		csgcr_cmd_t latch;
		logic       cmd_par;
		logic       pend;
		logic       line_s1;
		logic       line_s2;
	} csgcr_core_st_t;

	csgcr_core_st_t st_reg;
	csgcr_core_st_t st_next;

	logic [CS_IN_N-1:0] cs_in_n;
	logic               any_cs;
	logic               accept;
	logic               gate_open;
	logic               mismatch;
	csgcr_word_t        push_word;
	csgcr_word_t        head_word;

	assign cs_in_n   = {chip_select_d, chip_select_c, chip_select_b, chip_select_a};
	assign any_cs    = csgcr_any_cs(cs_in_n);
	assign accept    = in_valid && in_ready;
	assign gate_open = !gating_enable || any_cs;

	// odd total of ones over command plus parity bit
	assign mismatch = st_reg.pend && (st_reg.cmd_par ^ parity_in);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_next = st_reg;
		if (accept && gate_open) begin
			st_next.latch = cmd_in;
		end
		st_next.pend    = accept && any_cs;
		st_next.cmd_par = csgcr_parity(cmd_in);
		st_next.line_s1 = !parity_error_flag_n_i;
		st_next.line_s2 = st_reg.line_s1;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.latch <= CMD_RST;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign shared_error_seen = st_reg.line_s2;

	////////////////////////////////////////////////////////////////////////////////
	// output buffer

	always_comb begin
		push_word          = WORD_RST;
		push_word.cmd      = st_next.latch;
		push_word.ctl.cs_n = {chip_select_b, chip_select_a};
		push_word.ctl.cke  = cke_in;
		push_word.ctl.odt  = odt_in;
	end

	csgcr_buf u_buf (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.in_word   (push_word),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_word  (head_word)
	);

	assign redriven_outputs    = head_word.cmd;
	assign redriven_select_out = head_word.ctl.cs_n;
	assign redriven_cke        = head_word.ctl.cke;
	assign redriven_odt        = head_word.ctl.odt;

	////////////////////////////////////////////////////////////////////////////////
	// error reporting

	csgcr_perr u_perr (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.mismatch (mismatch && clk_en),
		.flag_o   (parity_error_flag_n_o),
		.flag_oe  (parity_error_flag_n_oe)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_gate_hold;
		(clk_en && accept && gating_enable && !any_cs) |=> st_reg.latch == $past(st_reg.latch);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("latch moved while gated");

	property p_gate_cs;
		(clk_en && accept && gating_enable && any_cs) |=> st_reg.latch == $past(cmd_in);
	endproperty
	a_gate_cs: assert property (p_gate_cs) else $error("latch missed selected cmd");

	property p_gate_off;
		(clk_en && accept && !gating_enable) |=> st_reg.latch == $past(cmd_in);
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("latch missed ungated cmd");

	property p_ctl_redrive;
		(clk_en && accept && !out_valid && !any_cs && gating_enable)
			|=> redriven_select_out == $past({chip_select_b, chip_select_a})
			&& redriven_cke == $past(cke_in) && out_valid;
	endproperty
	a_ctl_redrive: assert property (p_ctl_redrive) else $error("controls not re-driven");

	property p_mismatch;
		(clk_en && accept && any_cs)
			##1 (clk_en && ($past(csgcr_parity(cmd_in)) ^ parity_in)) |-> mismatch;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("parity error missed");

	property p_no_check;
		(clk_en && !(accept && any_cs)) |=> !mismatch;
	endproperty
	a_no_check: assert property (p_no_check) else $error("check without select");

	property p_err_latency;
		// a mismatch on the second edge after reset release falls in the blanking window
		(clk_en && mismatch ##1 clk_en ##1 1'b1) |-> ##[0:1] parity_error_flag_n_oe
			or $past(sys_rst, 4);
	endproperty
	a_err_latency: assert property (p_err_latency) else $error("error flag late");

	property p_reset;
		disable iff (1'b0)
		sys_rst |=> (redriven_outputs == CMD_RST && redriven_select_out == 2'h0
			&& !out_valid && !parity_error_flag_n_oe);
	endproperty
	a_reset: assert property (p_reset) else $error("reset did not clear outputs");

	c_gated_hold: cover property (clk_en && accept && gating_enable && !any_cs);
	c_ungated:    cover property (clk_en && accept && !gating_enable);
	c_mismatch:   cover property (clk_en && mismatch);

endmodule

// >>> verification/csgcr_sink.sv
`timescale 1ns/1ps
module csgcr_sink (
	// stall and second-module control from the bench
	input  wire logic stall,
	input  wire logic other_low,
	// dram side of the block
	output      logic out_ready,
	// shared open-drain error line
	input  wire logic err_o,
	input  wire logic err_oe,
	output      logic err_line
);
	assign out_ready = ~stall;
	// pull-up on the shared line, any module may pull it low
	assign err_line = ((err_oe && !err_o) || other_low) ? 1'b0 : 1'b1;
endmodule

// >>> verification/tb_cs_gated_command_register_parity.sv
`timescale 1ns/1ps
module tb_cs_gated_command_register_parity;
	import csgcr_pkg::*;
	logic                mclk = 1'b0;
	logic                sys_rst = 1'b1;
	logic                in_valid = 1'b0;
	logic                in_ready;
	csgcr_cmd_t          cmd_in = '0;
	logic [3:0]          cs_n = 4'hf;
	logic                cke_in = 1'b0;
	logic                odt_in = 1'b0;
	logic                parity_in = 1'b0;
	logic                gating_enable = 1'b0;
	logic                out_valid;
	logic                out_ready;
	csgcr_cmd_t          q_cmd;
	logic [CS_OUT_N-1:0] q_cs;
	logic                q_cke;
	logic                q_odt;
	logic                err_line;
	logic                err_o;
	logic                err_oe;
	logic                seen;
	logic                stall = 1'b0;
	logic                other_low = 1'b0;
	int                  error_cnt = 0;
	int                  samples_checked = 0;
	always #20 mclk = ~mclk;
	csgcr_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .in_valid(in_valid),
		.in_ready(in_ready), .cmd_in(cmd_in), .chip_select_a(cs_n[0]),
		.chip_select_b(cs_n[1]), .chip_select_c(cs_n[2]), .chip_select_d(cs_n[3]),
		.cke_in(cke_in), .odt_in(odt_in), .parity_in(parity_in),
		.gating_enable(gating_enable), .out_valid(out_valid), .out_ready(out_ready),
		.redriven_outputs(q_cmd), .redriven_select_out(q_cs), .redriven_cke(q_cke),
		.redriven_odt(q_odt), .parity_error_flag_n_i(err_line),
		.parity_error_flag_n_o(err_o), .parity_error_flag_n_oe(err_oe),
		.shared_error_seen(seen));
	csgcr_sink sink_u (.stall(stall), .other_low(other_low), .out_ready(out_ready),
		.err_o(err_o), .err_oe(err_oe), .err_line(err_line));
	////////////////////////////////////////////////////////////////
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic do_reset();
		sys_rst = 1'b1;
		repeat (10) tick();
		chk("rst cmd", q_cmd, 0);
		chk("rst ctl", {q_cs, q_cke, q_odt, out_valid, err_oe}, 0);
		sys_rst = 1'b0;
	endtask
	// command on one edge, its parity on the next; flip forces a mismatch when a chip select is low
	task automatic send(input csgcr_cmd_t c, input logic [3:0] cs, input logic flip);
		cmd_in = c;
		cs_n = cs;
		in_valid = 1'b1;
		tick();
		in_valid = 1'b0;
		cs_n = 4'hf;
		parity_in = (^c) ^ flip;
		tick();
		parity_in = 1'b0;
	endtask
	task automatic err_walk(input csgcr_cmd_t c, input logic [3:0] cs, input logic flip,
		input logic hit);
		send(c, cs, flip);
		chk("flag e2", err_oe, 0);
		tick();
		chk("flag e3", err_oe, hit);
		chk("line low", err_line, !hit);
		tick();
		chk("flag e4", err_oe, hit);
		tick();
		chk("flag e5", err_oe, 0);
		chk("line", err_line, 1);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_blank();
		do_reset();
		send(22'h000001, 4'he, 1'b1);
		repeat (3) begin
			chk("blank", err_oe, 0);
			tick();
		end
		$display("test blank done");
	endtask
	task automatic t_gating();
		gating_enable = 1'b1;
		cke_in = 1'b1;
		send(22'h12a5c3, 4'he, 1'b0);
		chk("gate a", q_cmd, 22'h12a5c3);
		chk("sel a", {q_cs, q_cke}, 3'h5);
		odt_in = 1'b1;
		send(22'h3f00ff, 4'hf, 1'b0);
		chk("gate none", q_cmd, 22'h12a5c3);
		chk("sel none", {q_cs, q_odt}, 3'h7);
		send(22'h0abcde, 4'h7, 1'b0);
		chk("gate d", q_cmd, 22'h0abcde);
		gating_enable = 1'b0;
		send(22'h2c0ffe, 4'hf, 1'b0);
		chk("no gate", q_cmd, 22'h2c0ffe);
		$display("test gating done");
	endtask
	task automatic t_parity();
		err_walk(22'h000007, 4'he, 1'b1, 1'b1);
		err_walk(22'h000007, 4'he, 1'b0, 1'b0);
		err_walk(22'h3fffff, 4'hb, 1'b1, 1'b1);
		err_walk(22'h000003, 4'hf, 1'b1, 1'b0);
		$display("test parity done");
	endtask
	task automatic t_buffer();
		int n;
		n = 0;
		stall = 1'b1;
		in_valid = 1'b1;
		while (in_ready === 1'b1 && n < 8) begin
			cmd_in = 22'h000010 + n;
			tick();
			n++;
		end
		in_valid = 1'b0;
		chk("fill", n, 2);
		chk("head", q_cmd, 22'h000010);
		stall = 1'b0;
		tick();
		chk("second", q_cmd, 22'h000011);
		chk("room", in_ready, 1);
		$display("test buffer done");
	endtask
	task automatic t_shared();
		other_low = 1'b1;
		repeat (3) tick();
		chk("seen low", seen, 1);
		chk("no drive", err_oe, 0);
		other_low = 1'b0;
		repeat (3) tick();
		chk("seen high", seen, 0);
		$display("test shared done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		error_cnt++;
		$display("timeout");
		stop_test();
	end
	initial begin
		do_reset();
		t_gating();
		t_parity();
		t_buffer();
		t_shared();
		t_blank();
		stop_test();
	end
endmodule
